// *** hw/mbfh_regs.vh ***
`ifndef MBFH_REGS_VH
`define MBFH_REGS_VH
// Summary of operation
// - Function 3 returns consecutive 16-bit registers from start address, count long.
// - Each register is one 16-bit word, sent high byte then low byte.
// - Largest read count is a build parameter: 2, 4, 40 or 120.
// - Read count above the configured maximum answers exception 3.
// - Read with bad start address or bad count answers exception 2.
// - Registers of a read run beyond the defined range return zero.
// - Read answer: address, function, byte count of twice count, data, checksum.
// - Inactive or failed channel reads as NaN (float) or overflow (integer).
// - Function 6 writes one register and echoes address and data.
// - Single writes to 0x03xx, 0xffxx or float locations answer exception 2.
// - Protected register or out-of-range data answers exception 4 (function 6; function 16 only at its first register).
// - Function 8 with zero subfunction echoes the whole frame unchanged.
// - Function 8 with nonzero subfunction answers exception 1, or 3 on oldest variant.
// - Function 16 writes consecutive registers from start with supplied data.
// - Largest multiple-write count is a build parameter: 2, 40 or 120.
// - Multiple-write answer carries start and count actually written.
// - Byte count not twice count, or count above the configured maximum, answers exception 3.
// - Multiple write with undefined start or bad count answers exception 2.
// - Multiple writes above 0xff00 store nothing and trigger a device command instead.
// - Invalid function or parameters get an exception answer unless broadcast.
// - Address 0 frames are executed but never answered.
// - Frame with an inter-character silence over the limit is discarded.
// - Every frame ends with a CRC, low byte first then high byte.

`define MBFH_FC_READ 8'h03
`define MBFH_FC_WR1 8'h06
`define MBFH_FC_ECHO 8'h08
`define MBFH_FC_WRN 8'h10
`define MBFH_EXC_NONE 8'h00
`define MBFH_EXC_FUNC 8'h01
`define MBFH_EXC_ADDR 8'h02
`define MBFH_EXC_VALUE 8'h03
`define MBFH_EXC_FAIL 8'h04
`define MBFH_EXC_FLAG 8'h80
`define MBFH_BCAST 8'h00
`define MBFH_CMD_HI_A 8'h03
`define MBFH_CMD_HI_B 8'hff
`define MBFH_CMD_BASE 16'hff00
`define MBFH_CRC_INIT 16'hffff
`define MBFH_CRC_POLY 16'ha001
`define MBFH_NAN_HI 16'h7fc0
`define MBFH_NAN_LO 16'h0000
`define MBFH_OVL_HI 16'h7fff
`define MBFH_OVL_LO 16'hffff
`define MBFH_ZERO_WORD 16'h0000
`define MBFH_FIX_LEN 9'h008
`define MBFH_WRN_OVH 9'h009
`define MBFH_MIN_LEN 9'h004
`define MBFH_BUF_DEPTH 9'h100
`define MBFH_CLK_NS 10
`define MBFH_T15_SLOW_NS 1718750
`define MBFH_T35_SLOW_NS 4010417
`define MBFH_T15_FAST_NS 750000
`define MBFH_T35_FAST_NS 1750000
`endif

// *** hw/mbfh_crc16.v ***
`include "mbfh_regs.vh"
`default_nettype none
module mbfh_crc16 (
  input wire sys_clk,
  input wire nrst,
  input wire clear,
  input wire en,
  input wire [7:0] data,
  output reg [15:0] crc_q
);

  // One whole byte per clock, reflected polynomial
  function [15:0] crc_step;
    input [15:0] c;
    input [7:0] d;
    integer i;
    reg [15:0] t;
    begin
      t = c ^ {8'h00, d};
      for (i = 0; i < 8; i = i + 1) begin
        t = t[0] ? ((t >> 1) ^ `MBFH_CRC_POLY) : (t >> 1);
      end
      crc_step = t;
    end
  endfunction

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      crc_q <= `MBFH_CRC_INIT;
    end else if (clear) begin
      crc_q <= `MBFH_CRC_INIT;
    end else if (en) begin
      crc_q <= crc_step(crc_q, data);
    end
  end

endmodule // mbfh_crc16
`default_nettype wire

// *** hw/mbfh_gap_timer.v ***
`default_nettype none
module mbfh_gap_timer #(
  parameter [23:0] T15_SLOW = 24'h000001,
  parameter [23:0] T35_SLOW = 24'h000002,
  parameter [23:0] T15_FAST = 24'h000001,
  parameter [23:0] T35_FAST = 24'h000002
) (
  input wire sys_clk,
  input wire nrst,
  input wire fast,
  input wire byte_seen,
  output reg char_gap_q,
  output reg frame_end_q
);

  reg [23:0] cnt_q;
  reg run_q;
  wire [23:0] lim15 = fast ? T15_FAST : T15_SLOW;
  wire [23:0] lim35 = fast ? T35_FAST : T35_SLOW;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 24'h000000;
      run_q <= 1'b0;
      char_gap_q <= 1'b0;
      frame_end_q <= 1'b0;
    end else begin
      frame_end_q <= 1'b0;
      if (byte_seen) begin
        cnt_q <= 24'h000000;
        run_q <= 1'b1;
        char_gap_q <= 1'b0;
      end else if (run_q) begin
        cnt_q <= cnt_q + 24'h000001;
        if (cnt_q >= lim15) begin
          char_gap_q <= 1'b1;
        end
        if (cnt_q >= lim35) begin
          run_q <= 1'b0;
          frame_end_q <= 1'b1;
        end
      end
    end
  end

endmodule // mbfh_gap_timer
`default_nettype wire

// *** hw/mbfh_top.v ***
`include "mbfh_regs.vh"
`default_nettype none
module mbfh_top #(
  parameter [7:0] READ_MAX = 8'h78,
  parameter [7:0] WRITE_MAX = 8'h78,
  parameter [7:0] ECHO_EXC = `MBFH_EXC_FUNC,
  parameter [23:0] T15_SLOW = `MBFH_T15_SLOW_NS / `MBFH_CLK_NS,
  parameter [23:0] T35_SLOW =
    (`MBFH_T35_SLOW_NS + `MBFH_CLK_NS - 1) / `MBFH_CLK_NS,
  parameter [23:0] T15_FAST = `MBFH_T15_FAST_NS / `MBFH_CLK_NS,
  parameter [23:0] T35_FAST =
    (`MBFH_T35_FAST_NS + `MBFH_CLK_NS - 1) / `MBFH_CLK_NS
) (
  input wire sys_clk,
  input wire nrst,
  input wire [7:0] slave_bus_address,
  input wire baud_fast,
  input wire rx_valid,
  input wire [7:0] rx_data,
  output reg tx_valid_q,
  output reg [7:0] tx_data_q,
  input wire tx_ready,
  output reg [15:0] map_addr_q,
  input wire [15:0] map_rd_data,
  input wire map_defined,
  input wire map_float,
  input wire map_protected,
  input wire map_data_ok,
  input wire map_chan_bad,
  input wire map_low_word,
  output reg wr_en_q,
  output reg cmd_strobe_q,
  output reg [15:0] wr_addr_q,
  output reg [15:0] wr_data_q
);

  // ********************************************************************
  // States and answer kinds
  // ********************************************************************
  localparam [4:0] S_RX = 5'h01;
  localparam [4:0] S_DEC = 5'h02;
  localparam [4:0] S_CHK = 5'h04;
  localparam [4:0] S_WR = 5'h08;
  localparam [4:0] S_TX = 5'h10;
  localparam [1:0] K_EXC = 2'h0;
  localparam [1:0] K_ECHO = 2'h1;
  localparam [1:0] K_READ = 2'h2;
  localparam [1:0] K_WRN = 2'h3;

  function is_cmd_range;
    input [15:0] a;
    begin
      is_cmd_range = (a[15:8] == `MBFH_CMD_HI_A) ||
        (a[15:8] == `MBFH_CMD_HI_B);
    end
  endfunction

  function is_virtual;
    input [15:0] a;
    begin
      is_virtual = a > `MBFH_CMD_BASE;
    end
  endfunction

  reg [7:0] mem [0:255];
  reg [4:0] state_q;
  reg [8:0] rx_cnt_q;
  reg [8:0] len_q;
  reg ovf_q;
  reg gap_bad_q;
  reg bcast_q;
  reg [7:0] fc_q;
  reg [15:0] start_q;
  reg [15:0] count_q;
  reg [7:0] bcnt_q;
  reg [15:0] stage_q;
  reg [15:0] wcnt_q;
  reg [7:0] exc_q;
  reg [1:0] kind_q;
  reg [8:0] resp_len_q;
  reg [8:0] tx_idx_q;
  reg [7:0] chk_exc;
  reg [15:0] rd_word;
  reg [7:0] tx_byte;

  wire char_gap;
  wire frame_end;
  wire [15:0] rx_crc;
  wire [15:0] tx_crc;
  wire in_rx = state_q == S_RX;
  wire byte_seen = rx_valid && in_rx;
  wire slot = !tx_valid_q || tx_ready;
  wire body = tx_idx_q < resp_len_q;
  wire last = tx_idx_q == (resp_len_q + 9'h002);
  wire tx_load = (state_q == S_TX) && slot && body;
  wire [7:0] next_idx = 8'h09 + {wcnt_q[6:0], 1'b0};
  wire [15:0] wcnt_inc = wcnt_q + 16'h0001;
  // A frame ends in S_DEC only when intact and addressed to us or broadcast
  wire frame_ok = (rx_crc == 16'h0000) && (rx_cnt_q >= `MBFH_MIN_LEN) &&
    !ovf_q && !gap_bad_q && ((mem[0] == slave_bus_address) ||
    (mem[0] == `MBFH_BCAST));

  // ********************************************************************
  // Character timing and checksums
  // ********************************************************************
  mbfh_gap_timer #(
    .T15_SLOW(T15_SLOW),
    .T35_SLOW(T35_SLOW),
    .T15_FAST(T15_FAST),
    .T35_FAST(T35_FAST)
  ) u_gap (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .fast(baud_fast),
    .byte_seen(byte_seen),
    .char_gap_q(char_gap),
    .frame_end_q(frame_end)
  );

  // Residue over data plus received CRC is zero for a good frame
  mbfh_crc16 u_rx_crc (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clear(frame_end),
    .en(byte_seen),
    .data(rx_data),
    .crc_q(rx_crc)
  );

  mbfh_crc16 u_tx_crc (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clear(state_q == S_DEC),
    .en(tx_load),
    .data(tx_byte),
    .crc_q(tx_crc)
  );

  // ********************************************************************
  // Request checks
  // ********************************************************************
  always @* begin
    chk_exc = `MBFH_EXC_NONE;
    case (fc_q)
      `MBFH_FC_READ: begin
        if (len_q != `MBFH_FIX_LEN) begin
          chk_exc = `MBFH_EXC_VALUE;
        end else if (count_q > {8'h00, READ_MAX}) begin
          chk_exc = `MBFH_EXC_VALUE;
        end else if (count_q == 16'h0000 || !map_defined) begin
          chk_exc = `MBFH_EXC_ADDR;
        end
      end
      `MBFH_FC_WR1: begin
        if (len_q != `MBFH_FIX_LEN) begin
          chk_exc = `MBFH_EXC_VALUE;
        end else if (is_cmd_range(start_q) || map_float || !map_defined) begin
          chk_exc = `MBFH_EXC_ADDR;
        end else if (map_protected || !map_data_ok) begin
          chk_exc = `MBFH_EXC_FAIL;
        end
      end
      `MBFH_FC_ECHO: begin
        if (len_q != `MBFH_FIX_LEN) begin
          chk_exc = `MBFH_EXC_VALUE;
        end else if (mem[2] != 8'h00 || mem[3] != 8'h00) begin
          chk_exc = ECHO_EXC;
        end
      end
      `MBFH_FC_WRN: begin
        if ({8'h00, bcnt_q} != {count_q[14:0], 1'b0} ||
            len_q != ({1'b0, bcnt_q} + `MBFH_WRN_OVH)) begin
          chk_exc = `MBFH_EXC_VALUE;
        end else if (count_q > {8'h00, WRITE_MAX}) begin
          chk_exc = `MBFH_EXC_VALUE;
        end else if (count_q == 16'h0000 || !map_defined) begin
          chk_exc = `MBFH_EXC_ADDR;
        end
      end
      default: begin
        chk_exc = `MBFH_EXC_FUNC;
      end
    endcase
  end

  // ********************************************************************
  // Answer byte generation
  // ********************************************************************
  always @* begin
    if (!map_defined) begin
      rd_word = `MBFH_ZERO_WORD;
    end else if (map_chan_bad) begin
      if (map_float) begin
        rd_word = map_low_word ? `MBFH_NAN_LO : `MBFH_NAN_HI;
      end else begin
        rd_word = map_low_word ? `MBFH_OVL_LO : `MBFH_OVL_HI;
      end
    end else begin
      rd_word = map_rd_data;
    end
    case (kind_q)
      K_EXC: begin
        if (tx_idx_q == 9'h000) begin
          tx_byte = mem[0];
        end else if (tx_idx_q == 9'h001) begin
          tx_byte = fc_q | `MBFH_EXC_FLAG;
        end else begin
          tx_byte = exc_q;
        end
      end
      K_READ: begin
        if (tx_idx_q < 9'h002) begin
          tx_byte = mem[tx_idx_q[7:0]];
        end else if (tx_idx_q == 9'h002) begin
          tx_byte = {count_q[6:0], 1'b0};
        end else begin
          tx_byte = tx_idx_q[0] ? rd_word[15:8] : rd_word[7:0];
        end
      end
      K_WRN: begin
        if (tx_idx_q == 9'h004) begin
          tx_byte = wcnt_q[15:8];
        end else if (tx_idx_q == 9'h005) begin
          tx_byte = wcnt_q[7:0];
        end else begin
          tx_byte = mem[tx_idx_q[7:0]];
        end
      end
      default: begin
        tx_byte = mem[tx_idx_q[7:0]];
      end
    endcase
  end

  // ********************************************************************
  // Receive buffer
  // ********************************************************************
  // No reset on the array: contents are only read after a full frame
  always @(posedge sys_clk) begin
    if (byte_seen && rx_cnt_q < `MBFH_BUF_DEPTH) begin
      mem[rx_cnt_q[7:0]] <= rx_data;
    end
  end

  // ********************************************************************
  // Sequencer
  // ********************************************************************
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_RX;
      rx_cnt_q <= 9'h000;
      len_q <= 9'h000;
      ovf_q <= 1'b0;
      gap_bad_q <= 1'b0;
      bcast_q <= 1'b0;
      fc_q <= 8'h00;
      start_q <= 16'h0000;
      count_q <= 16'h0000;
      bcnt_q <= 8'h00;
      stage_q <= 16'h0000;
      wcnt_q <= 16'h0000;
      exc_q <= 8'h00;
      kind_q <= K_EXC;
      resp_len_q <= 9'h000;
      tx_idx_q <= 9'h000;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      map_addr_q <= 16'h0000;
      wr_en_q <= 1'b0;
      cmd_strobe_q <= 1'b0;
      wr_addr_q <= 16'h0000;
      wr_data_q <= 16'h0000;
    end else begin
      wr_en_q <= 1'b0;
      cmd_strobe_q <= 1'b0;
      case (state_q)
        S_RX: begin
          if (byte_seen) begin
            if (rx_cnt_q < `MBFH_BUF_DEPTH) begin
              rx_cnt_q <= rx_cnt_q + 9'h001;
            end else begin
              ovf_q <= 1'b1;
            end
            if (char_gap && rx_cnt_q != 9'h000) begin
              gap_bad_q <= 1'b1;
            end
          end else if (frame_end) begin
            rx_cnt_q <= 9'h000;
            ovf_q <= 1'b0;
            gap_bad_q <= 1'b0;
            len_q <= rx_cnt_q;
            if (frame_ok) begin
              state_q <= S_DEC;
            end
          end
        end
        S_DEC: begin
          fc_q <= mem[1];
          start_q <= {mem[2], mem[3]};
          count_q <= {mem[4], mem[5]};
          bcnt_q <= mem[6];
          bcast_q <= mem[0] == `MBFH_BCAST;
          map_addr_q <= {mem[2], mem[3]};
          // F6 carries data where F16 carries the count
          stage_q <= (mem[1] == `MBFH_FC_WRN) ? {mem[7], mem[8]} :
            {mem[4], mem[5]};
          wcnt_q <= 16'h0000;
          tx_idx_q <= 9'h000;
          state_q <= S_CHK;
        end
        S_CHK: begin
          exc_q <= chk_exc;
          kind_q <= K_EXC;
          resp_len_q <= 9'h003;
          state_q <= bcast_q ? S_RX : S_TX;
          if (chk_exc == `MBFH_EXC_NONE) begin
            case (fc_q)
              `MBFH_FC_READ: begin
                kind_q <= K_READ;
                resp_len_q <= 9'h003 + {count_q[7:0], 1'b0};
              end
              `MBFH_FC_WR1: begin
                wr_en_q <= 1'b1;
                wr_addr_q <= map_addr_q;
                wr_data_q <= stage_q;
                kind_q <= K_ECHO;
                resp_len_q <= 9'h006;
              end
              `MBFH_FC_ECHO: begin
                kind_q <= K_ECHO;
                resp_len_q <= 9'h006;
              end
              default: begin
                kind_q <= K_WRN;
                resp_len_q <= 9'h006;
                state_q <= S_WR;
              end
            endcase
          end
        end
        S_WR: begin
          if (map_protected || !map_data_ok) begin
            // Stop at the first bad word; report what got through
            exc_q <= `MBFH_EXC_FAIL;
            if (wcnt_q == 16'h0000) begin
              kind_q <= K_EXC;
              resp_len_q <= 9'h003;
            end
            state_q <= bcast_q ? S_RX : S_TX;
          end else begin
            if (is_virtual(map_addr_q)) begin
              cmd_strobe_q <= 1'b1;
            end else begin
              wr_en_q <= 1'b1;
            end
            wr_addr_q <= map_addr_q;
            wr_data_q <= stage_q;
            wcnt_q <= wcnt_inc;
            map_addr_q <= map_addr_q + 16'h0001;
            stage_q <= {mem[next_idx], mem[next_idx + 8'h01]};
            if (wcnt_inc == count_q) begin
              state_q <= bcast_q ? S_RX : S_TX;
            end
          end
        end
        S_TX: begin
          if (slot) begin
            if (last) begin
              tx_valid_q <= 1'b0;
              state_q <= S_RX;
            end else begin
              tx_valid_q <= 1'b1;
              tx_idx_q <= tx_idx_q + 9'h001;
              if (body) begin
                tx_data_q <= tx_byte;
              end else if (tx_idx_q == resp_len_q) begin
                tx_data_q <= tx_crc[7:0];
              end else begin
                tx_data_q <= tx_crc[15:8];
              end
              if (body && kind_q == K_READ && tx_idx_q >= 9'h004 &&
                  !tx_idx_q[0]) begin
                map_addr_q <= map_addr_q + 16'h0001;
              end
            end
          end
        end
        default: begin
          state_q <= S_RX;
        end
      endcase
    end
  end

endmodule // mbfh_top
`default_nettype wire

// *** verif/mbfh_top_sva.sv ***
`default_nettype none
// ****************************************************************
// Port checker for the function handler
// ****************************************************************
module mbfh_top_chk #(
  parameter [23:0] T35 = 24'h000032
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] slave_bus_address,
  input wire logic rx_valid,
  input wire logic tx_valid_q,
  input wire logic [7:0] tx_data_q,
  input wire logic tx_ready,
  input wire logic [15:0] map_addr_q,
  input wire logic wr_en_q,
  input wire logic cmd_strobe_q,
  input wire logic [15:0] wr_addr_q
);
  logic [23:0] quiet_q;
  // Saturates so a long idle line never wraps back below the limit
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) quiet_q <= 24'h000000;
    else if (rx_valid) quiet_q <= 24'h000000;
    else if (quiet_q != 24'hffffff) quiet_q <= quiet_q + 24'h000001;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence tx_start;
    $rose(tx_valid_q);
  endsequence
  sequence tx_stall;
    tx_valid_q && !tx_ready;
  endsequence
  tx_opens_addr_a: assert property (
    tx_start |-> tx_data_q == slave_bus_address)
    else $error("answer does not open with own address");
  tx_after_quiet_a: assert property (
    tx_start |-> quiet_q >= T35)
    else $error("answer began before frame end silence");
  tx_byte_hold_a: assert property (
    tx_stall |=> tx_valid_q && $stable(tx_data_q))
    else $error("answer byte changed while stalled");
  wr_cmd_excl_a: assert property (
    !(wr_en_q && cmd_strobe_q))
    else $error("store and command pulse together");
  cmd_range_a: assert property (
    cmd_strobe_q |-> wr_addr_q > 16'hff00)
    else $error("command outside command range");
  store_range_a: assert property (
    wr_en_q |-> wr_addr_q <= 16'hff00)
    else $error("store into command range");
  wr_map_addr_a: assert property (
    (wr_en_q || cmd_strobe_q) |-> wr_addr_q == $past(map_addr_q))
    else $error("write address differs from checked address");
  wr_before_tx_a: assert property (
    (wr_en_q || cmd_strobe_q) |-> !tx_valid_q)
    else $error("write during answer");
  wr_addr_hold_a: assert property (
    !(wr_en_q || cmd_strobe_q) |-> $stable(wr_addr_q))
    else $error("write address moved without a write");
endmodule // mbfh_top_chk

bind mbfh_top mbfh_top_chk #(.T35(T35_SLOW)) i_chk (
  .sys_clk(sys_clk),
  .nrst(nrst),
  .slave_bus_address(slave_bus_address),
  .rx_valid(rx_valid),
  .tx_valid_q(tx_valid_q),
  .tx_data_q(tx_data_q),
  .tx_ready(tx_ready),
  .map_addr_q(map_addr_q),
  .wr_en_q(wr_en_q),
  .cmd_strobe_q(cmd_strobe_q),
  .wr_addr_q(wr_addr_q)
);
`default_nettype wire

// *** verif/mbfh_master_model.sv ***
`default_nettype none
// ****************************************************************
// Serial bus master seen at the byte level
// ****************************************************************
module mbfh_master_model (
  input wire logic sys_clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_valid_q,
  input wire logic [7:0] tx_data_q,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic slow = 1'b0;
  logic [1:0] ph = 2'h0;
  logic [7:0] got[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end
  // Slow mode takes one byte in four to stress the stall path
  always @(posedge sys_clk) begin
    #1;
    ph = ph + 2'h1;
    tx_ready = !slow || ph == 2'h0;
  end
  always @(posedge sys_clk) begin
    if (tx_valid_q === 1'b1 && tx_ready === 1'b1) got.push_back(tx_data_q);
  end
  // Bytes go out in frame order, checksum low byte first
  task automatic send(input logic [7:0] q[$], input int gap);
    foreach (q[i]) begin
      if (i == gap) repeat (30) @(posedge sys_clk);
      @(posedge sys_clk);
      #1;
      rx_valid = 1'b1;
      rx_data = q[i];
      @(posedge sys_clk);
      #1;
      rx_valid = 1'b0;
      // Line no longer carries the byte once the strobe is gone
      rx_data = ~q[i];
    end
  endtask
endmodule // mbfh_master_model
`default_nettype wire

// *** verif/mbfh_top_tb.sv ***
`default_nettype none
// ****************************************************************
// Function handler testbench
// ****************************************************************
module mbfh_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef logic [7:0] mbfh_bq_t[$];
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic rx_valid, tx_valid_q, tx_ready, wr_en_q, cmd_strobe_q;
  logic [7:0] rx_data, tx_data_q;
  logic [15:0] map_addr_q, map_rd_data, wr_addr_q, wr_data_q;
  logic map_defined, map_float, map_protected, map_data_ok;
  logic map_chan_bad, map_low_word;
  // Own address and baud select come from variables, not tied pins
  logic [7:0] own_addr = 8'h01;
  logic baud_sel = 1'b0;
  logic [32:0] wq[$];
  int err_count = 0;
  int n_tests = 0;
  always #5 sys_clk = ~sys_clk;
  // Small register map: 0x0000-0x002f and the command page exist
  always @* begin
    map_defined = map_addr_q < 16'h0030 || map_addr_q >= 16'hff00;
    map_float = map_addr_q < 16'h000c;
    map_protected = map_addr_q == 16'h0020;
    map_data_ok = map_addr_q != 16'h0015;
    map_chan_bad = map_addr_q[15:1] == 15'h0002;
    map_low_word = map_float && map_addr_q[0];
    map_rd_data = map_addr_q ^ 16'h5a5a;
  end
  always @(posedge sys_clk) begin
    if (wr_en_q === 1'b1 || cmd_strobe_q === 1'b1)
      wq.push_back({cmd_strobe_q, wr_addr_q, wr_data_q});
  end
  mbfh_top #(.READ_MAX(8'h04), .WRITE_MAX(8'h02),
    .T15_SLOW(24'h000014), .T35_SLOW(24'h000032)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .slave_bus_address(own_addr),
    .baud_fast(baud_sel), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q), .tx_ready(tx_ready),
    .map_addr_q(map_addr_q), .map_rd_data(map_rd_data),
    .map_defined(map_defined), .map_float(map_float),
    .map_protected(map_protected), .map_data_ok(map_data_ok),
    .map_chan_bad(map_chan_bad), .map_low_word(map_low_word),
    .wr_en_q(wr_en_q), .cmd_strobe_q(cmd_strobe_q),
    .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q));
  mbfh_master_model i_mst (.sys_clk(sys_clk), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q),
    .tx_ready(tx_ready));
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic mbfh_bq_t add_crc(input mbfh_bq_t q);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    return q;
  endfunction
  // gap: index of a late byte, -2 spoils the checksum, -1 clean frame
  task automatic xact(input mbfh_bq_t req, input mbfh_bq_t rsp,
                      input int gap, input int nw, input logic [32:0] lw);
    mbfh_bq_t r, e;
    int k;
    r = add_crc(req);
    e = (rsp.size() > 0) ? add_crc(rsp) : rsp;
    if (gap == -2) r[r.size() - 1] = r[r.size() - 1] ^ 8'h01;
    i_mst.got.delete();
    wq.delete();
    i_mst.send(r, gap);
    k = 0;
    while (i_mst.got.size() < e.size() && k < 300) begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 300) begin
      err_count++;
      $display("mismatch at %0t: answer never completed", $time);
      summarize;
    end
    repeat (120) @(posedge sys_clk);
    check(i_mst.got.size(), e.size());
    foreach (e[i]) if (i < i_mst.got.size()) check(i_mst.got[i], e[i]);
    check(wq.size(), nw);
    if (nw > 0 && wq.size() > 0) check(wq[wq.size() - 1], lw);
  endtask
  task automatic s_read;
    xact('{8'h01, 8'h03, 8'h00, 8'h2e, 8'h00, 8'h04}, '{8'h01, 8'h03, 8'h08,
      8'h5a, 8'h74, 8'h5a, 8'h75, 8'h00, 8'h00, 8'h00, 8'h00},
      -1, 0, 33'h0);
    i_mst.slow = 1'b1;
    xact('{8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02}, '{8'h01, 8'h03, 8'h04,
      8'h7f, 8'hc0, 8'h00, 8'h00}, -1, 0, 33'h0);
    i_mst.slow = 1'b0;
  endtask
  task automatic s_limits;
    xact('{8'h01, 8'h03, 8'h00, 8'h10, 8'h00, 8'h05},
      '{8'h01, 8'h83, 8'h03}, -1, 0, 33'h0);
    xact('{8'h01, 8'h03, 8'h00, 8'h10, 8'h00, 8'h00},
      '{8'h01, 8'h83, 8'h02}, -1, 0, 33'h0);
    xact('{8'h01, 8'h03, 8'h00, 8'h40, 8'h00, 8'h01},
      '{8'h01, 8'h83, 8'h02}, -1, 0, 33'h0);
  endtask
  task automatic s_wr1;
    xact('{8'h01, 8'h06, 8'h00, 8'h14, 8'h12, 8'h34},
      '{8'h01, 8'h06, 8'h00, 8'h14, 8'h12, 8'h34},
      -1, 1, {1'b0, 16'h0014, 16'h1234});
    xact('{8'h01, 8'h06, 8'h03, 8'h14, 8'h00, 8'h01},
      '{8'h01, 8'h86, 8'h02}, -1, 0, 33'h0);
    xact('{8'h01, 8'h06, 8'hff, 8'h01, 8'h00, 8'h01},
      '{8'h01, 8'h86, 8'h02}, -1, 0, 33'h0);
    xact('{8'h01, 8'h06, 8'h00, 8'h02, 8'h00, 8'h01},
      '{8'h01, 8'h86, 8'h02}, -1, 0, 33'h0);
    xact('{8'h01, 8'h06, 8'h00, 8'h20, 8'h00, 8'h01},
      '{8'h01, 8'h86, 8'h04}, -1, 0, 33'h0);
    xact('{8'h01, 8'h06, 8'h00, 8'h15, 8'h00, 8'h01},
      '{8'h01, 8'h86, 8'h04}, -1, 0, 33'h0);
  endtask
  task automatic s_echo;
    xact('{8'h01, 8'h08, 8'h00, 8'h00, 8'hab, 8'hcd},
      '{8'h01, 8'h08, 8'h00, 8'h00, 8'hab, 8'hcd}, -1, 0, 33'h0);
    xact('{8'h01, 8'h08, 8'h00, 8'h01, 8'hab, 8'hcd},
      '{8'h01, 8'h88, 8'h01}, -1, 0, 33'h0);
  endtask
  task automatic s_wrn;
    xact('{8'h01, 8'h10, 8'h00, 8'h16, 8'h00, 8'h02, 8'h04, 8'h11, 8'h11,
      8'h22, 8'h22}, '{8'h01, 8'h10, 8'h00, 8'h16, 8'h00, 8'h02},
      -1, 2, {1'b0, 16'h0017, 16'h2222});
    xact('{8'h01, 8'h10, 8'h00, 8'h14, 8'h00, 8'h02, 8'h04, 8'haa, 8'haa,
      8'h00, 8'h01}, '{8'h01, 8'h10, 8'h00, 8'h14, 8'h00, 8'h01},
      -1, 1, {1'b0, 16'h0014, 16'haaaa});
    xact('{8'h01, 8'h10, 8'h00, 8'h14, 8'h00, 8'h03, 8'h06, 8'h00, 8'h01,
      8'h00, 8'h02, 8'h00, 8'h03}, '{8'h01, 8'h90, 8'h03},
      -1, 0, 33'h0);
    xact('{8'h01, 8'h10, 8'h00, 8'h16, 8'h00, 8'h02, 8'h03, 8'h11, 8'h11,
      8'h22}, '{8'h01, 8'h90, 8'h03}, -1, 0, 33'h0);
    xact('{8'h01, 8'h10, 8'h00, 8'h40, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01},
      '{8'h01, 8'h90, 8'h02}, -1, 0, 33'h0);
    xact('{8'h01, 8'h10, 8'h00, 8'h20, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01},
      '{8'h01, 8'h90, 8'h04}, -1, 0, 33'h0);
    xact('{8'h01, 8'h10, 8'hff, 8'h01, 8'h00, 8'h01, 8'h02, 8'h00, 8'h05},
      '{8'h01, 8'h10, 8'hff, 8'h01, 8'h00, 8'h01},
      -1, 1, {1'b1, 16'hff01, 16'h0005});
  endtask
  task automatic s_drop;
    xact('{8'h00, 8'h06, 8'h00, 8'h14, 8'hbe, 8'hef}, '{},
      -1, 1, {1'b0, 16'h0014, 16'hbeef});
    xact('{8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, '{},
      -2, 0, 33'h0);
    xact('{8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, '{},
      3, 0, 33'h0);
    xact('{8'h02, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, '{},
      -1, 0, 33'h0);
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    $display("mismatch at %0t: run too long", $time);
    summarize;
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    s_read;
    s_limits;
    s_wr1;
    s_echo;
    s_wrn;
    s_drop;
    summarize;
  end
endmodule // mbfh_top_tb
`default_nettype wire
